// ===== rtl/lmt_unit.sv
// Purpose: Logic ops with flags, and multiply/divide cycle and access counts
// Assumes: APB master waits on pready; adder (a) and access set (b/c) set by software
// Notes: Ops finish after their fixed cycle count; busy shows meanwhile
`timescale 1ns/1ps
`include "lmt_cfg.svh"
`default_nettype none
module lmt_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire lmt_pkg::lmt_apb_req_type apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic busy
);
    import lmt_pkg::*;

    ////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_r;
    logic [31:0] opnd_r;
    logic [31:0] acc_r;
    logic [31:0] res_r;
    logic [31:0] adj_r;
    lmt_flags_type flags_r;
    logic [5:0] cnt_r;
    logic [5:0] total_r;
    logic [5:0] acc_cnt_r;
    logic busy_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [5:0] cyc_nxt;
    logic [5:0] acs_nxt;
    logic [31:0] res_nxt;
    lmt_flags_type flags_nxt;
    lmt_op_type op;
    lmt_src_type src;
    logic wordsz;
    logic [5:0] adder_a;
    logic [5:0] acc_set;
    logic acc_store;
    logic start;
    logic wr_acc;
    logic [31:0] ctrl_view;

    // The starting write is decoded directly: ctrl_r only takes it at that same edge
    assign ctrl_view = start ? apb_req.pwdata : ctrl_r;
    assign op = lmt_op_type'(ctrl_view[3:0]);
    assign src = lmt_src_type'(ctrl_view[5:4]);
    assign wordsz = ctrl_view[6];
    assign acc_store = ctrl_view[7]; // Operand is destination
    assign adder_a = adj_r[5:0];
    assign acc_set = adj_r[13:8];

    // Pick one of three counts by zero/overflow outcome
    function automatic logic [5:0] pick3(input logic z, input logic o,
                                          input logic [5:0] a, input logic [5:0] b,
                                          input logic [5:0] c);
        pick3 = z ? a : (o ? b : c);
    endfunction : pick3

    ////////////////////////////////////////////////////////////////////
    // Result, flags, cycle and access count of the staged operation
    always_comb begin
        logic [31:0] q;
        logic [15:0] bdiv;
        logic [31:0] wdiv;
        logic [7:0] bq8;
        logic [15:0] wq16;
        logic [15:0] lhs;
        logic [15:0] rhs;
        logic bz;
        logic bov;
        logic wov;
        q = 32'h0000_0000;
        bdiv = 16'h0000;
        wdiv = 32'h0000_0000;
        bq8 = 8'h00;
        wq16 = 16'h0000;
        lhs = 16'h0000;
        rhs = 16'h0000;
        bz = 1'b0;
        bov = 1'b0;
        wov = 1'b0;
        res_nxt = acc_r;
        flags_nxt = flags_r;
        cyc_nxt = 6'h01;
        acs_nxt = 6'h00;
        // Accumulator-only word form uses high half against low
        lhs = (src == LMT_SRC_ACC && wordsz) ? acc_r[31:16] : acc_r[15:0];
        rhs = (src == LMT_SRC_ACC) ? acc_r[15:0] : opnd_r[15:0];
        unique case (op)
            LMT_AND, LMT_OR, LMT_XOR, LMT_NOT: begin
                unique case (op)
                    LMT_AND: q[15:0] = lhs & rhs;
                    LMT_OR: q[15:0] = lhs | rhs;
                    LMT_XOR: q[15:0] = lhs ^ rhs;
                    default: q[15:0] = (src == LMT_SRC_ACC) ? ~acc_r[15:0] : ~opnd_r[15:0];
                endcase
                if (!wordsz) begin
                    q[15:8] = 8'h00;
                end
                // Result goes to accumulator low half or back to operand
                res_nxt = acc_r;
                if (acc_store && src != LMT_SRC_ACC && src != LMT_SRC_IMM) begin
                    res_nxt = {16'h0000, wordsz ? q[15:0] : {opnd_r[15:8], q[7:0]}};
                end else if (wordsz) begin
                    res_nxt[15:0] = q[15:0];
                end else begin
                    res_nxt[7:0] = q[7:0];
                end
                // N and Z follow result, V cleared, carry untouched
                flags_nxt.n = wordsz ? q[15] : q[7];
                flags_nxt.z = wordsz ? (q[15:0] == 16'h0000) : (q[7:0] == 8'h00);
                flags_nxt.v = 1'b0;
                flags_nxt.c = flags_r.c;
                if (op == LMT_NOT && src == LMT_SRC_ACC) begin
                    cyc_nxt = `LMT_CY_LOGIC_ACC;
                end else if (src == LMT_SRC_ACC || src == LMT_SRC_IMM) begin
                    cyc_nxt = `LMT_CY_LOGIC_ACC;
                end else if (src == LMT_SRC_REG) begin
                    cyc_nxt = `LMT_CY_LOGIC_REG;
                end else if (acc_store || op == LMT_NOT) begin
                    cyc_nxt = 6'(`LMT_CY_LOGIC_MEMW + adder_a);
                    acs_nxt = 6'(acc_set << 1);
                end else begin
                    cyc_nxt = 6'(`LMT_CY_LOGIC_MEMA + adder_a);
                    acs_nxt = acc_set;
                end
            end
            LMT_DIVB: begin
                rhs = (src == LMT_SRC_ACC) ? {8'h00, acc_r[7:0]} : {8'h00, opnd_r[7:0]};
                lhs = (src == LMT_SRC_ACC) ? acc_r[31:16] : acc_r[15:0];
                bov = (rhs[7:0] == 8'h00) || (lhs[15:8] >= rhs[7:0]);
                if (!bov) begin
                    bdiv = lhs / rhs;
                    bq8 = bdiv[7:0];
                end
                bz = !bov && (bq8 == 8'h00);
                flags_nxt.v = bov;
                flags_nxt.c = bov;
                if (!bov) begin
                    res_nxt[7:0] = bq8;
                end
                unique case (src)
                    LMT_SRC_ACC: cyc_nxt = pick3(bz, bov, 6'h03, 6'h07, 6'h0F);
                    LMT_SRC_REG, LMT_SRC_IMM: cyc_nxt = pick3(bz, bov, 6'h04, 6'h08, 6'h10);
                    default: begin
                        cyc_nxt = 6'(pick3(bz, bov, 6'h06, 6'h09, 6'h13) + adder_a);
                        acs_nxt = (bz || bov) ? acc_set : 6'(acc_set << 1);
                    end
                endcase
            end
            LMT_DIVW: begin
                wov = (opnd_r[15:0] == 16'h0000) || (acc_r[31:16] >= opnd_r[15:0]);
                if (!wov) begin
                    wdiv = acc_r / {16'h0000, opnd_r[15:0]};
                    wq16 = wdiv[15:0];
                    res_nxt[15:0] = wq16;
                end
                bz = !wov && (wq16 == 16'h0000);
                flags_nxt.v = wov;
                flags_nxt.c = wov;
                if (src == LMT_SRC_MEM) begin
                    cyc_nxt = 6'(pick3(bz, wov, 6'h06, 6'h08, 6'h1A) + adder_a);
                    acs_nxt = (bz || wov) ? acc_set : 6'(acc_set << 1);
                end else begin
                    cyc_nxt = pick3(bz, wov, 6'h04, 6'h07, 6'h16);
                end
            end
            LMT_MULB: begin
                rhs = (src == LMT_SRC_ACC) ? {8'h00, acc_r[23:16]} : {8'h00, opnd_r[7:0]};
                res_nxt[15:0] = 16'(acc_r[7:0]) * 16'(rhs[7:0]);
                unique case (src)
                    LMT_SRC_ACC: cyc_nxt = (rhs[7:0] == 8'h00) ? 6'h03 : 6'h07;
                    LMT_SRC_REG, LMT_SRC_IMM: cyc_nxt = (rhs[7:0] == 8'h00) ? 6'h04 : 6'h08;
                    default: begin
                        cyc_nxt = 6'(((rhs[7:0] == 8'h00) ? 6'h05 : 6'h09) + adder_a);
                        acs_nxt = acc_set;
                    end
                endcase
            end
            default: begin
                rhs = (src == LMT_SRC_ACC) ? acc_r[31:16] : opnd_r[15:0];
                res_nxt = acc_r[15:0] * rhs;
                unique case (src)
                    LMT_SRC_ACC: cyc_nxt = (rhs == 16'h0000) ? 6'h03 : 6'h0B;
                    LMT_SRC_REG, LMT_SRC_IMM: cyc_nxt = (rhs == 16'h0000) ? 6'h04 : 6'h0C;
                    default: begin
                        cyc_nxt = 6'(((rhs == 16'h0000) ? 6'h05 : 6'h0D) + adder_a);
                        acs_nxt = acc_set;
                    end
                endcase
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // APB decode; writes ignored while an operation runs
    assign start = wr_acc && apb_req.paddr[11:0] == `LMT_A_CTRL &&
                   apb_req.pwdata[`LMT_CTRL_GO];
    assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite && pready_r && !busy_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 32'h0000_0000;
            opnd_r <= 32'h0000_0000;
            acc_r <= 32'h0000_0000;
            adj_r <= 32'h0000_0000;
        end else if (wr_acc) begin
            unique case (apb_req.paddr[11:0])
                `LMT_A_CTRL: ctrl_r <= {1'b0, apb_req.pwdata[30:0]};
                `LMT_A_OPND: opnd_r <= apb_req.pwdata;
                `LMT_A_ACC: acc_r <= apb_req.pwdata;
                `LMT_A_ADJ: adj_r <= apb_req.pwdata;
                default: ;
            endcase
        end
    end

    // Cycle counter; result lands when the count runs out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
            cnt_r <= 6'h00;
            total_r <= 6'h00;
            acc_cnt_r <= 6'h00;
            res_r <= 32'h0000_0000;
            flags_r <= lmt_flags_type'(`LMT_CCR_RST);
        end else if (start) begin
            busy_r <= 1'b1;
            cnt_r <= cyc_nxt;
            total_r <= cyc_nxt;
            acc_cnt_r <= acs_nxt;
        end else if (busy_r) begin
            cnt_r <= 6'(cnt_r - 6'h01);
            if (cnt_r == 6'h01) begin
                busy_r <= 1'b0;
                res_r <= res_nxt;
                flags_r <= flags_nxt;
            end
        end
    end

    // Read mux; unmapped reads return zero with error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= apb_req.psel && !apb_req.penable;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            if (apb_req.psel && !apb_req.penable) begin
                unique case (apb_req.paddr[11:0])
                    `LMT_A_CTRL: prdata_r <= ctrl_r;
                    `LMT_A_OPND: prdata_r <= opnd_r;
                    `LMT_A_ACC: prdata_r <= acc_r;
                    `LMT_A_RES: prdata_r <= res_r;
                    `LMT_A_STAT: prdata_r <= {busy_r, 15'h0000, 4'(flags_r), acc_cnt_r, total_r};
                    `LMT_A_TIME: prdata_r <= {26'h0000000, cnt_r};
                    `LMT_A_ADJ: prdata_r <= adj_r;
                    default: pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign busy = busy_r;

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_div_acc_time;
        @(posedge pclk) disable iff (!presetn)
        start && op == LMT_DIVB && src == LMT_SRC_ACC |-> cyc_nxt inside {6'h03, 6'h07, 6'h0F};
    endproperty
    a_div_acc_time: assert property (p_div_acc_time) else $error("byte divide time");
    property p_divb_reg;
        @(posedge pclk) disable iff (!presetn)
        start && op == LMT_DIVB && src == LMT_SRC_REG |-> cyc_nxt inside {6'h04, 6'h08, 6'h10};
    endproperty
    a_divb_reg: assert property (p_divb_reg) else $error("reg divide time");
    property p_divw_reg;
        @(posedge pclk) disable iff (!presetn)
        start && op == LMT_DIVW && src == LMT_SRC_REG |-> cyc_nxt inside {6'h04, 6'h07, 6'h16};
    endproperty
    a_divw_reg: assert property (p_divw_reg) else $error("word divide time");
    property p_mulb_acc;
        @(posedge pclk) disable iff (!presetn)
        start && op == LMT_MULB && src == LMT_SRC_ACC |->
            cyc_nxt == ((acc_r[23:16] == 8'h00) ? 6'h03 : 6'h07);
    endproperty
    a_mulb_acc: assert property (p_mulb_acc) else $error("byte multiply time");
    property p_mulw_acc;
        @(posedge pclk) disable iff (!presetn)
        start && op == LMT_MULW && src == LMT_SRC_ACC |->
            cyc_nxt == ((acc_r[31:16] == 16'h0000) ? 6'h03 : 6'h0B);
    endproperty
    a_mulw_acc: assert property (p_mulw_acc) else $error("word multiply time");
    property p_busy_len;
        @(posedge pclk) disable iff (!presetn)
        start |=> busy_r [*2];
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too short");
    property p_logic_v;
        @(posedge pclk) disable iff (!presetn)
        busy_r && cnt_r == 6'h01 && op inside {LMT_AND, LMT_OR, LMT_XOR, LMT_NOT}
            |=> !flags_r.v && flags_r.c == $past(flags_r.c);
    endproperty
    a_logic_v: assert property (p_logic_v) else $error("logic flags");
    property p_mem_div_acc;
        @(posedge pclk) disable iff (!presetn)
        start && op == LMT_DIVW && src == LMT_SRC_MEM |=>
            acc_cnt_r == acc_set || acc_cnt_r == 6'(acc_set << 1);
    endproperty
    a_mem_div_acc: assert property (p_mem_div_acc) else $error("divide accesses");
    c_div: cover property (@(posedge pclk) disable iff (!presetn) start && op == LMT_DIVB);
    c_mul: cover property (@(posedge pclk) disable iff (!presetn) start && op == LMT_MULW);
    c_rmw: cover property (@(posedge pclk) disable iff (!presetn)
        start && src == LMT_SRC_MEM && acc_store);
    c_divw_mem: cover property (@(posedge pclk) disable iff (!presetn)
        start && op == LMT_DIVW && src == LMT_SRC_MEM);
    c_not_word: cover property (@(posedge pclk) disable iff (!presetn)
        start && op == LMT_NOT && wordsz);
    property p_divb_mem;
        @(posedge pclk) disable iff (!presetn)
        start && op == LMT_DIVB && src == LMT_SRC_MEM |->
            cyc_nxt inside {6'(6'h06 + adder_a), 6'(6'h09 + adder_a), 6'(6'h13 + adder_a)};
    endproperty
    a_divb_mem: assert property (p_divb_mem) else $error("memory byte divide time");
    property p_divw_mem;
        @(posedge pclk) disable iff (!presetn)
        start && op == LMT_DIVW && src == LMT_SRC_MEM |->
            cyc_nxt inside {6'(6'h06 + adder_a), 6'(6'h08 + adder_a), 6'(6'h1A + adder_a)};
    endproperty
    a_divw_mem: assert property (p_divw_mem) else $error("memory word divide time");
    property p_mulb_reg;
        @(posedge pclk) disable iff (!presetn)
        start && op == LMT_MULB && src == LMT_SRC_REG |->
            cyc_nxt == ((opnd_r[7:0] == 8'h00) ? 6'h04 : 6'h08);
    endproperty
    a_mulb_reg: assert property (p_mulb_reg) else $error("reg byte multiply time");
    property p_mulb_mem;
        @(posedge pclk) disable iff (!presetn)
        start && op == LMT_MULB && src == LMT_SRC_MEM |->
            cyc_nxt == 6'(((opnd_r[7:0] == 8'h00) ? 6'h05 : 6'h09) + adder_a);
    endproperty
    a_mulb_mem: assert property (p_mulb_mem) else $error("memory byte multiply time");
    property p_mulw_reg;
        @(posedge pclk) disable iff (!presetn)
        start && op == LMT_MULW && src == LMT_SRC_REG |->
            cyc_nxt == ((opnd_r[15:0] == 16'h0000) ? 6'h04 : 6'h0C);
    endproperty
    a_mulw_reg: assert property (p_mulw_reg) else $error("reg word multiply time");
    property p_mulw_mem;
        @(posedge pclk) disable iff (!presetn)
        start && op == LMT_MULW && src == LMT_SRC_MEM |->
            cyc_nxt == 6'(((opnd_r[15:0] == 16'h0000) ? 6'h05 : 6'h0D) + adder_a);
    endproperty
    a_mulw_mem: assert property (p_mulw_mem) else $error("memory word multiply time");
    property p_logic_rmw_acs;
        @(posedge pclk) disable iff (!presetn)
        start && op inside {LMT_AND, LMT_OR, LMT_XOR, LMT_NOT} &&
            src == LMT_SRC_MEM && acc_store |=> acc_cnt_r == 6'(acc_set << 1);
    endproperty
    a_logic_rmw_acs: assert property (p_logic_rmw_acs) else $error("update accesses");
    property p_not_inv;
        @(posedge pclk) disable iff (!presetn)
        busy_r && cnt_r == 6'h01 && op == LMT_NOT && src == LMT_SRC_REG && acc_store &&
            !wordsz |=> res_r[7:0] == ~$past(opnd_r[7:0]);
    endproperty
    a_not_inv: assert property (p_not_inv) else $error("byte invert result");
    property p_keep_high;
        @(posedge pclk) disable iff (!presetn)
        busy_r && cnt_r == 6'h01 && op inside {LMT_AND, LMT_OR, LMT_XOR, LMT_NOT} &&
            !acc_store |=> res_r[31:16] == $past(acc_r[31:16]);
    endproperty
    a_keep_high: assert property (p_keep_high) else $error("high half changed");
endmodule : lmt_unit
`default_nettype wire

// ===== rtl/lmt_cfg.svh
// Purpose: Constants for the logic and multiply/divide timing unit
// Assumes: One 20 MHz clock, APB register access
// Notes: Overview follows
// Overview of operation
// - Acc byte divide: 3 zero, 7 overflow, 15
// - Register byte divide: 4, 8, 16 cycles
// - Memory byte divide: 6/9/19 plus adder
// - Register word divide: 4, 7, 22 cycles
// - Memory word divide: 6/8/26 plus adder
// - Memory divide accesses: one set, else double
// - Acc byte multiply: 3 if high zero, 7
// - Register byte multiply: 4 if zero, 8
// - Memory byte multiply: 5/9 plus adder
// - Acc word multiply: 3 if high zero, 11
// - Register word multiply: 4 if zero, 12
// - Memory word multiply: 5/13 plus adder
// - Byte logic into acc updates NZ, clears V
// - Byte logic writeback; memory form atomic, two accesses
// - Byte invert in place; NZ set, V cleared
// - Acc word logic: high op low, 2 cycles
// - Word logic forms; memory target atomic update
// - Word invert: register 3, memory 5 plus adder
`ifndef LMT_CFG_SVH
`define LMT_CFG_SVH
`define LMT_A_CTRL 12'h000
`define LMT_A_OPND 12'h004
`define LMT_A_ACC 12'h008
`define LMT_A_RES 12'h00C
`define LMT_A_STAT 12'h010
`define LMT_A_TIME 12'h014
`define LMT_A_ADJ 12'h018
`define LMT_CTRL_GO 31
`define LMT_CY_LOGIC_ACC 6'h02
`define LMT_CY_LOGIC_REG 6'h03
`define LMT_CY_LOGIC_MEMA 6'h04
`define LMT_CY_LOGIC_MEMW 6'h05
`define LMT_CCR_RST 4'h0
`endif

// ===== rtl/lmt_pkg.sv
// Purpose: Types of the logic and multiply/divide timing unit
// Assumes: Nothing
// Notes: Operation codes sit in the control word low bits
package lmt_pkg;
    typedef enum logic [3:0] {
        LMT_AND, LMT_OR, LMT_XOR, LMT_NOT,
        LMT_DIVB, LMT_DIVW, LMT_MULB, LMT_MULW
    } lmt_op_type;
    typedef enum logic [1:0] {LMT_SRC_ACC, LMT_SRC_IMM, LMT_SRC_REG, LMT_SRC_MEM} lmt_src_type;
    typedef struct packed {
        logic [31:0] paddr;
        logic pwrite;
        logic psel;
        logic penable;
        logic [31:0] pwdata;
    } lmt_apb_req_type;
    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } lmt_flags_type;
endpackage : lmt_pkg

// ===== verification/lmt_tb.sv
// Purpose: Self-checking bench for the logic and multiply/divide timing unit
// Assumes: APB answers with one access phase; adder and access set come from ADJ
// Notes: Cycle counts are measured on busy and read back from the status word
`timescale 1ns/1ps
`default_nettype none
`include "lmt_cfg.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end
module testbench;
    import lmt_pkg::*;
    localparam int ADD = 3;
    localparam int SET = 2;
    logic pclk;
    logic presetn;
    lmt_apb_req_type apb_req;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic busy;
    logic err_q;
    logic [31:0] rd;
    int n_errors = 0;
    int n_compared = 0;
    int busy_cnt = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Clock, reset and device under test
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    lmt_unit i_lmt_unit (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy)
    );
    // Pre-edge sampling of busy avoids racing the design's own update
    always @(posedge pclk) begin
        if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus tasks
    task automatic close_out;
        if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out

    // Starts on the next edge, so a release and a new setup never share a time step
    task automatic apb(input logic [31:0] a, input logic wr, input logic [31:0] wd);
        int i;
        @(posedge pclk);
        apb_req <= '{paddr: a, pwrite: wr, psel: 1'b1, penable: 1'b0, pwdata: wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            n_errors++;
            close_out();
        end
        rd = prdata;
        err_q = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] cw(lmt_op_type op, lmt_src_type s, logic w, logic d);
        return {1'b1, 23'h0, d, w, s, op};
    endfunction : cw

    // Loads operands, starts, and checks busy length, cycle and access counts
    task automatic run(input logic [31:0] c, input logic [31:0] ac, input logic [31:0] op,
                       input int cy, input int na);
        int i;
        int b0;
        apb(`LMT_A_ACC, 1'b1, ac);
        apb(`LMT_A_OPND, 1'b1, op);
        apb(`LMT_A_CTRL, 1'b1, c);
        b0 = busy_cnt;
        for (i = 0; i < 100; i++) begin
            @(posedge pclk);
            #1;
            if (busy !== 1'b1 && i > 0) break;
        end
        if (i == 100) begin
            n_errors++;
            close_out();
        end
        `CHK(busy_cnt - b0, cy)
        apb(`LMT_A_STAT, 1'b0, 32'h0);
        `CHK(rd[5:0], cy[5:0])
        `CHK(rd[11:6], na[5:0])
    endtask : run

    // Logic op: also checks result width and the four flags {n,z,v,c}
    task automatic lop(input logic [31:0] c, input logic [31:0] ac, input logic [31:0] op,
                       input int cy, input int na, input logic [15:0] r, input logic [3:0] f);
        run(c, ac, op, cy, na);
        `CHK(rd[15:12], f)
        apb(`LMT_A_RES, 1'b0, 32'h0);
        if (c[6]) `CHK(rd[15:0], r)
        else `CHK(rd[7:0], r[7:0])
    endtask : lop

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        presetn = 1'b0;
        apb_req = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(`LMT_A_STAT, 1'b0, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(err_q, 1'b0)
        apb(32'h0000_0020, 1'b0, 32'h0);
        `CHK(err_q, 1'b1)
        apb(32'h0000_0024, 1'b1, 32'h0000_0001);
        `CHK(err_q, 1'b1)
        apb(`LMT_A_ADJ, 1'b1, {18'h0, SET[5:0], 2'b0, ADD[5:0]});
        run(cw(LMT_MULB, LMT_SRC_ACC, 0, 0), 32'h0000_0003, 0, 3, 0);
        run(cw(LMT_MULB, LMT_SRC_ACC, 0, 0), 32'h0001_0003, 0, 7, 0);
        run(cw(LMT_MULB, LMT_SRC_REG, 0, 0), 3, 32'h0000_0100, 4, 0);
        run(cw(LMT_MULB, LMT_SRC_REG, 0, 0), 3, 3, 8, 0);
        run(cw(LMT_MULB, LMT_SRC_MEM, 0, 0), 3, 0, 5 + ADD, SET);
        run(cw(LMT_MULB, LMT_SRC_MEM, 0, 0), 3, 9, 9 + ADD, SET);
        run(cw(LMT_MULW, LMT_SRC_ACC, 1, 0), 32'h0000_0003, 0, 3, 0);
        run(cw(LMT_MULW, LMT_SRC_ACC, 1, 0), 32'h0001_0003, 0, 11, 0);
        run(cw(LMT_MULW, LMT_SRC_REG, 1, 0), 3, 32'h0001_0000, 4, 0);
        run(cw(LMT_MULW, LMT_SRC_REG, 1, 0), 3, 32'h0000_8000, 12, 0);
        run(cw(LMT_MULW, LMT_SRC_MEM, 1, 0), 3, 0, 5 + ADD, SET);
        run(cw(LMT_MULW, LMT_SRC_MEM, 1, 0), 3, 7, 13 + ADD, SET);
        run(cw(LMT_DIVB, LMT_SRC_ACC, 0, 0), 32'h0000_0005, 0, 3, 0);
        run(cw(LMT_DIVB, LMT_SRC_ACC, 0, 0), 32'h0010_0000, 0, 7, 0);
        run(cw(LMT_DIVB, LMT_SRC_ACC, 0, 0), 32'h0010_0002, 0, 15, 0);
        run(cw(LMT_DIVB, LMT_SRC_REG, 0, 0), 0, 5, 4, 0);
        run(cw(LMT_DIVB, LMT_SRC_REG, 0, 0), 32'h10, 2, 16, 0);
        run(cw(LMT_DIVB, LMT_SRC_MEM, 0, 0), 0, 5, 6 + ADD, SET);
        run(cw(LMT_DIVB, LMT_SRC_MEM, 0, 0), 32'h10, 0, 9 + ADD, SET);
        run(cw(LMT_DIVB, LMT_SRC_MEM, 0, 0), 32'h10, 2, 19 + ADD, 2 * SET);
        run(cw(LMT_DIVW, LMT_SRC_REG, 1, 0), 0, 5, 4, 0);
        run(cw(LMT_DIVW, LMT_SRC_REG, 1, 0), 32'h10, 2, 22, 0);
        run(cw(LMT_DIVW, LMT_SRC_REG, 1, 0), 32'h10, 0, 7, 0);
        run(cw(LMT_DIVW, LMT_SRC_MEM, 1, 0), 0, 5, 6 + ADD, SET);
        run(cw(LMT_DIVW, LMT_SRC_MEM, 1, 0), 32'h10, 0, 8 + ADD, SET);
        run(cw(LMT_DIVW, LMT_SRC_MEM, 1, 0), 32'h10, 2, 26 + ADD, 2 * SET);
        // Quotient too wide for a byte; leaves carry set for the flag checks below
        run(cw(LMT_DIVB, LMT_SRC_REG, 0, 0), 32'h1000, 1, 8, 0);
        lop(cw(LMT_AND, LMT_SRC_IMM, 0, 0), 32'hF0, 32'h81, 2, 0, 16'h80, 4'b1001);
        lop(cw(LMT_XOR, LMT_SRC_REG, 0, 0), 32'h55, 32'h55, 3, 0, 16'h00, 4'b0101);
        lop(cw(LMT_AND, LMT_SRC_MEM, 0, 0), 32'h3C, 32'h0F, 4 + ADD, SET, 16'h0C, 4'b0001);
        lop(cw(LMT_OR, LMT_SRC_REG, 0, 1), 32'h0F, 32'hF0, 3, 0, 16'hFF, 4'b1001);
        lop(cw(LMT_XOR, LMT_SRC_MEM, 0, 1), 32'h01, 32'h81, 5 + ADD, 2 * SET, 16'h80, 4'b1001);
        lop(cw(LMT_NOT, LMT_SRC_ACC, 0, 0), 32'hFF, 0, 2, 0, 16'h00, 4'b0101);
        lop(cw(LMT_NOT, LMT_SRC_REG, 0, 1), 0, 32'h7F, 3, 0, 16'h80, 4'b1001);
        lop(cw(LMT_NOT, LMT_SRC_MEM, 0, 1), 0, 32'h00, 5 + ADD, 2 * SET, 16'hFF, 4'b1001);
        lop(cw(LMT_AND, LMT_SRC_ACC, 1, 0), 32'h0F0F_00FF, 0, 2, 0, 16'h000F, 4'b0001);
        `CHK(rd[31:16], 16'h0F0F)
        lop(cw(LMT_OR, LMT_SRC_ACC, 1, 0), 32'h8000_0001, 0, 2, 0, 16'h8001, 4'b1001);
        lop(cw(LMT_XOR, LMT_SRC_ACC, 1, 0), 32'h1234_1234, 0, 2, 0, 16'h0000, 4'b0101);
        lop(cw(LMT_AND, LMT_SRC_IMM, 1, 0), 32'hFFFF, 32'h8001, 2, 0, 16'h8001, 4'b1001);
        lop(cw(LMT_OR, LMT_SRC_REG, 1, 0), 32'h0100, 32'h0010, 3, 0, 16'h0110, 4'b0001);
        lop(cw(LMT_XOR, LMT_SRC_MEM, 1, 0), 32'hFF00, 32'h0F00, 4 + ADD, SET, 16'hF000, 4'b1001);
        lop(cw(LMT_AND, LMT_SRC_MEM, 1, 1), 32'h00F0, 32'h0F00, 5 + ADD, 2 * SET, 16'h0, 4'b0101);
        lop(cw(LMT_NOT, LMT_SRC_REG, 1, 1), 0, 32'h00FF, 3, 0, 16'hFF00, 4'b1001);
        lop(cw(LMT_NOT, LMT_SRC_MEM, 1, 1), 0, 32'hFFFF, 5 + ADD, 2 * SET, 16'h0, 4'b0101);
        lop(cw(LMT_NOT, LMT_SRC_ACC, 1, 0), 32'h7FFF, 0, 2, 0, 16'h8000, 4'b1001);
        // Writes during a run are dropped; the remaining count walks down from 22
        apb(`LMT_A_ACC, 1'b1, 32'h10);
        apb(`LMT_A_OPND, 1'b1, 32'h2);
        apb(`LMT_A_CTRL, 1'b1, cw(LMT_DIVW, LMT_SRC_REG, 1, 0));
        apb(`LMT_A_ACC, 1'b1, 32'hFFFF_FFFF);
        apb(`LMT_A_ACC, 1'b0, 32'h0);
        `CHK(rd, 32'h0000_0010)
        apb(`LMT_A_TIME, 1'b0, 32'h0);
        `CHK(rd, 32'h0000_000F)
        repeat (20) @(posedge pclk);
        `CHK(busy, 1'b0)
        apb(`LMT_A_RES, 1'b0, 32'h0);
        `CHK(rd[15:0], 16'h0008)
        close_out();
    end
endmodule : testbench
`default_nettype wire
